// *** rtl/itrp_pkg.sv ***
// Shared constants and types for the two-wire target register port
package itrp_pkg;
    // Bus address and byte framing
    localparam logic [6:0] TARGET_ADDR  = 7'h51;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] LAST_TX_BIT  = 4'h7;
    localparam logic [7:0] PTR_STEP     = 8'h01;
    localparam logic [7:0] PTR_RESET    = 8'h00;
    localparam int unsigned PTR_W       = 8;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned CNT_W       = 32;

    // Clock periods in ns
    localparam int unsigned SYS_CLK_NS  = 20;
    localparam int unsigned LINK_CLK_NS = 32;
    localparam int unsigned NS_PER_MS   = 1000000;

    // Timing figures in ms
    localparam int unsigned DEB_SHORT_MS = 1;
    localparam int unsigned DEB_LONG_MS  = 1000;
    localparam int unsigned TOUT_MS      = 950;

    // Longest times round down, least times round up
    localparam int unsigned DEB_SHORT_CYC = (DEB_SHORT_MS * NS_PER_MS) / SYS_CLK_NS;
    localparam int unsigned DEB_LONG_CYC  = (DEB_LONG_MS * NS_PER_MS) / SYS_CLK_NS;
    localparam int unsigned TOUT_CYC      = (TOUT_MS * NS_PER_MS + LINK_CLK_NS - 1) / LINK_CLK_NS;

    // Transfer state machine
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_ADDR   = 4'h1,
        ST_AACK   = 4'h2,
        ST_PTR    = 4'h3,
        ST_PACK   = 4'h4,
        ST_WDATA  = 4'h5,
        ST_DACK   = 4'h6,
        ST_RDATA  = 4'h7,
        ST_RACK   = 4'h8,
        ST_IGNORE = 4'h9
    } itrp_state_t;
endpackage

// *** rtl/itrp_regmem.sv ***
// Register memory with registered read data
`timescale 1ns/1ns
module itrp_regmem #(
    parameter int unsigned DW = 8,
    parameter int unsigned AW = 8
) (
    input  wire logic          sys_clk_in,
    input  wire logic          sys_rst_in,
    input  wire logic          wr_en_in,
    input  wire logic          rd_en_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    output logic      [DW-1:0] rd_data_out
);
    localparam int unsigned DEPTH = 1 << AW;

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0]            rd;
    } itrp_mem_t;

    itrp_mem_t q;
    itrp_mem_t next_q;

    // Write and read port; read data holds until the next read
    always_comb begin
        next_q = q;
        if (wr_en_in) begin
            next_q.mem[addr_in] = wr_data_in;
        end
        if (rd_en_in) begin
            next_q.rd = q.mem[addr_in];
        end
    end

    // Only the read register is reset; contents persist
    always_ff @(posedge sys_clk_in) begin
        q <= next_q;
        if (sys_rst_in) begin
            q.rd <= '0;
        end
    end

    assign rd_data_out = q.rd;
endmodule

// *** rtl/itrp_target.sv ***
// Two-wire target port giving a bus controller byte access to internal registers
`timescale 1ns/1ns
module itrp_target #(
    parameter int unsigned DEB_SHORT_CYCLES = itrp_pkg::DEB_SHORT_CYC,
    parameter int unsigned DEB_LONG_CYCLES  = itrp_pkg::DEB_LONG_CYC,
    parameter int unsigned TOUT_CYCLES      = itrp_pkg::TOUT_CYC
) (
    input  wire logic                          sys_clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic                          link_clk_in,
    input  wire logic                          link_rst_in,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe_out,
    input  wire logic                          backup_supply_state_in,
    input  wire logic                          low_voltage_flag_in,
    output logic                               access_ok_out,
    output logic                               wr_strobe_out,
    output logic [itrp_pkg::PTR_W-1:0]         wr_addr_out,
    output logic [itrp_pkg::DATA_W-1:0]        wr_data_out
);
    localparam int unsigned CW = itrp_pkg::CNT_W;

    // Short count at least one cycle, long count no shorter, timeout at least two cycles
    if (DEB_SHORT_CYCLES < 1 || DEB_LONG_CYCLES < DEB_SHORT_CYCLES || TOUT_CYCLES < 2) begin : g_bad_counts
        $error("itrp_target: bad timing counts");
    end

    typedef struct packed {
        logic                          bk_m;
        logic                          bk_s;
        logic                          lv_m;
        logic                          lv_s;
        logic                          rq_m;
        logic                          rq_s;
        logic                          rq_p;
        logic                          long_deb;
        logic [CW-1:0]                 deb;
        logic                          ok;
        logic                          wr_stb;
        logic [itrp_pkg::PTR_W-1:0]    wr_addr;
        logic [itrp_pkg::DATA_W-1:0]   wr_data;
    } itrp_sys_t;

    typedef struct packed {
        logic                          scl_m;
        logic                          scl_s;
        logic                          scl_p;
        logic                          sda_m;
        logic                          sda_s;
        logic                          sda_p;
        logic                          ok_m;
        logic                          ok_s;
        itrp_pkg::itrp_state_t         state;
        logic [3:0]                    cnt;
        logic [7:0]                    shreg;
        logic                          rw;
        logic [itrp_pkg::PTR_W-1:0]    ptr;
        logic                          oe;
        logic                          req_tgl;
        logic                          req_we;
        logic [itrp_pkg::PTR_W-1:0]    req_addr;
        logic [itrp_pkg::DATA_W-1:0]   req_data;
        logic [CW-1:0]                 tcnt;
    } itrp_link_t;

    itrp_sys_t                      s;
    itrp_sys_t                      next_s;
    itrp_link_t                     q;
    itrp_link_t                     next_q;
    logic [itrp_pkg::DATA_W-1:0]    mem_rd;
    logic                           mem_wr;
    logic                           mem_re;
    logic                           req_edge;
    logic [CW-1:0]                  deb_limit;

    // ---------------- System clock side ----------------
    assign req_edge  = s.rq_s ^ s.rq_p;
    assign mem_wr    = req_edge & q.req_we;
    assign mem_re    = req_edge & ~q.req_we;
    assign deb_limit = s.long_deb ? CW'(DEB_LONG_CYCLES - 1) : CW'(DEB_SHORT_CYCLES - 1);

    // Supply debounce and request crossing
    always_comb begin
        next_s        = s;
        next_s.bk_m   = backup_supply_state_in;
        next_s.bk_s   = s.bk_m;
        next_s.lv_m   = low_voltage_flag_in;
        next_s.lv_s   = s.lv_m;
        next_s.rq_m   = q.req_tgl;
        next_s.rq_s   = s.rq_m;
        next_s.rq_p   = s.rq_s;
        next_s.wr_stb = mem_wr;
        if (mem_wr) begin
            next_s.wr_addr = q.req_addr;
            next_s.wr_data = q.req_data;
        end
        if (s.bk_s) begin
            next_s.ok       = 1'b0;
            next_s.deb      = '0;
            next_s.long_deb = s.lv_s;
        end else if (!s.ok) begin
            next_s.long_deb = s.long_deb | s.lv_s;
            if (s.deb >= deb_limit) begin
                next_s.ok = 1'b1;
            end else begin
                next_s.deb = s.deb + CW'(1);
            end
        end
    end

    // System side registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Register storage; payload is stable while the toggle crosses
    itrp_regmem #(
        .DW (itrp_pkg::DATA_W),
        .AW (itrp_pkg::PTR_W)
    ) u_regmem (
        .sys_clk_in  (sys_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (mem_wr),
        .rd_en_in    (mem_re),
        .addr_in     (q.req_addr),
        .wr_data_in  (q.req_data),
        .rd_data_out (mem_rd)
    );

    assign access_ok_out = s.ok;
    assign wr_strobe_out = s.wr_stb;
    assign wr_addr_out   = s.wr_addr;
    assign wr_data_out   = s.wr_data;

    // ---------------- Link clock side ----------------
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic tout;
    logic live;

    // Edge and condition detect on second sync stage only
    assign scl_rise  = q.scl_s & ~q.scl_p;
    assign scl_fall  = ~q.scl_s & q.scl_p;
    assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign bus_stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    assign tout      = (q.tcnt == CW'(TOUT_CYCLES - 1));
    assign live      = q.ok_s & ~bus_start & ~bus_stop & ~tout;

    // Transfer state machine
    always_comb begin
        next_q       = q;
        next_q.scl_m = scl_in;
        next_q.scl_s = q.scl_m;
        next_q.scl_p = q.scl_s;
        next_q.sda_m = sda_in;
        next_q.sda_s = q.sda_m;
        next_q.sda_p = q.sda_s;
        next_q.ok_m  = s.ok;
        next_q.ok_s  = q.ok_m;
        next_q.tcnt  = (q.state == itrp_pkg::ST_IDLE) ? '0 : q.tcnt + CW'(1);
        if (!q.ok_s) begin
            next_q.state = itrp_pkg::ST_IDLE;
            next_q.oe    = 1'b0;
            next_q.tcnt  = '0;
        end else if (bus_start) begin
            next_q.state = itrp_pkg::ST_ADDR;
            next_q.cnt   = '0;
            next_q.oe    = 1'b0;
            next_q.tcnt  = '0;
        end else if (bus_stop) begin
            next_q.state = itrp_pkg::ST_IDLE;
            next_q.oe    = 1'b0;
        end else if (tout) begin
            next_q.state = itrp_pkg::ST_IDLE;
            next_q.oe    = 1'b0;
        end else begin
            case (q.state)
                itrp_pkg::ST_ADDR, itrp_pkg::ST_PTR, itrp_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        next_q.shreg = {q.shreg[6:0], q.sda_s};
                        next_q.cnt   = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == itrp_pkg::BYTE_BITS) begin
                        next_q.oe = 1'b1;
                        if (q.state == itrp_pkg::ST_ADDR) begin
                            if (q.shreg[7:1] == itrp_pkg::TARGET_ADDR) begin
                                next_q.rw    = q.shreg[0];
                                next_q.state = itrp_pkg::ST_AACK;
                                if (q.shreg[0]) begin
                                    next_q.req_tgl  = ~q.req_tgl;
                                    next_q.req_we   = 1'b0;
                                    next_q.req_addr = q.ptr;
                                end
                            end else begin
                                next_q.oe    = 1'b0;
                                next_q.state = itrp_pkg::ST_IGNORE;
                            end
                        end else if (q.state == itrp_pkg::ST_PTR) begin
                            next_q.ptr   = q.shreg;
                            next_q.state = itrp_pkg::ST_PACK;
                        end else begin
                            next_q.req_tgl  = ~q.req_tgl;
                            next_q.req_we   = 1'b1;
                            next_q.req_addr = q.ptr;
                            next_q.req_data = q.shreg;
                            next_q.ptr      = q.ptr + itrp_pkg::PTR_STEP;
                            next_q.state    = itrp_pkg::ST_DACK;
                        end
                    end
                end
                itrp_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        next_q.cnt = '0;
                        if (q.rw) begin
                            next_q.shreg = mem_rd;
                            next_q.oe    = ~mem_rd[7];
                            next_q.ptr   = q.ptr + itrp_pkg::PTR_STEP;
                            next_q.state = itrp_pkg::ST_RDATA;
                        end else begin
                            next_q.oe    = 1'b0;
                            next_q.state = itrp_pkg::ST_PTR;
                        end
                    end
                end
                itrp_pkg::ST_PACK, itrp_pkg::ST_DACK: begin
                    if (scl_fall) begin
                        next_q.oe    = 1'b0;
                        next_q.cnt   = '0;
                        next_q.state = itrp_pkg::ST_WDATA;
                    end
                end
                itrp_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        next_q.cnt = q.cnt + 4'h1;
                        if (q.cnt == itrp_pkg::LAST_TX_BIT) begin
                            next_q.oe    = 1'b0;
                            next_q.state = itrp_pkg::ST_RACK;
                        end else begin
                            next_q.shreg = {q.shreg[6:0], 1'b0};
                            next_q.oe    = ~q.shreg[6];
                        end
                    end
                end
                itrp_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (q.sda_s) begin
                            next_q.state = itrp_pkg::ST_IGNORE;
                        end else begin
                            next_q.req_tgl  = ~q.req_tgl;
                            next_q.req_we   = 1'b0;
                            next_q.req_addr = q.ptr;
                        end
                    end else if (scl_fall) begin
                        next_q.cnt   = '0;
                        next_q.shreg = mem_rd;
                        next_q.oe    = ~mem_rd[7];
                        next_q.ptr   = q.ptr + itrp_pkg::PTR_STEP;
                        next_q.state = itrp_pkg::ST_RDATA;
                    end
                end
                itrp_pkg::ST_IDLE, itrp_pkg::ST_IGNORE: begin
                    next_q.oe = 1'b0;
                end
                default: begin
                    next_q.state = itrp_pkg::ST_IDLE;
                    next_q.oe    = 1'b0;
                end
            endcase
        end
    end

    // Link side registers; pointer survives everything but reset
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            q       <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.ptr   <= itrp_pkg::PTR_RESET;
            q.state <= itrp_pkg::ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out    = 1'b0;
    assign sda_oe_out = q.oe;

    // ---------------- Checks ----------------
    default clocking cb_link @(posedge link_clk_in); endclocking
    default disable iff (link_rst_in);

    a_addr_match: assert property ((q.state == itrp_pkg::ST_AACK) |-> (q.shreg[7:1] == itrp_pkg::TARGET_ADDR))
        else $error("acknowledged a foreign address");
    a_dir_bit: assert property ((q.state == itrp_pkg::ST_AACK) |-> (q.rw == q.shreg[0]))
        else $error("direction bit not taken from bit zero");
    a_ack_held: assert property ((q.state inside {itrp_pkg::ST_AACK, itrp_pkg::ST_PACK, itrp_pkg::ST_DACK}
                                  && q.scl_s) |-> q.oe)
        else $error("ack released while clock high");
    a_nack_release: assert property ((q.state == itrp_pkg::ST_RACK) |-> !q.oe)
        else $error("data line held in controller ack slot");
    a_ignore_idle: assert property ((q.state == itrp_pkg::ST_IGNORE) |-> !q.oe)
        else $error("driving while ignoring");
    a_stop_ends: assert property ((q.ok_s && bus_stop) |=> (q.state == itrp_pkg::ST_IDLE && !q.oe))
        else $error("stop did not end transfer");
    a_restart_addr: assert property ((q.ok_s && bus_start) |=> (q.state == itrp_pkg::ST_ADDR && q.cnt == 4'h0))
        else $error("start did not restart address phase");
    a_ptr_load: assert property ((live && q.state == itrp_pkg::ST_PTR && scl_fall && q.cnt == itrp_pkg::BYTE_BITS)
                                 |=> (q.ptr == $past(q.shreg) && q.oe))
        else $error("pointer not loaded from first byte");
    a_ptr_step: assert property ((live && q.state == itrp_pkg::ST_WDATA && scl_fall && q.cnt == itrp_pkg::BYTE_BITS)
                                 |=> (q.ptr == $past(q.ptr) + itrp_pkg::PTR_STEP && q.req_we
                                      && q.req_addr == $past(q.ptr)))
        else $error("write did not store at pointer then step");
    a_read_step: assert property ((live && q.state == itrp_pkg::ST_RACK && scl_fall)
                                  |=> (q.state == itrp_pkg::ST_RDATA
                                       && q.ptr == $past(q.ptr) + itrp_pkg::PTR_STEP))
        else $error("read did not continue after ack");
    a_backup_reset: assert property (!q.ok_s |=> (q.state == itrp_pkg::ST_IDLE && !q.oe))
        else $error("bus active without access");
    a_timeout_abort: assert property ((q.ok_s && tout && !bus_start) |=> q.state == itrp_pkg::ST_IDLE)
        else $error("long transaction not aborted");
    a_ptr_kept: assert property ((q.ok_s && bus_stop) |=> $stable(q.ptr))
        else $error("pointer changed at stop");
    a_deb_block: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
                                  s.bk_s |=> !s.ok ##1 !s.ok)
        else $error("access granted during backup");

    c_write_byte: cover property (q.state == itrp_pkg::ST_WDATA ##1 q.state == itrp_pkg::ST_DACK);
    c_read_acked: cover property (q.state == itrp_pkg::ST_RACK ##1 q.state == itrp_pkg::ST_RDATA);
    c_read_nack: cover property (q.state == itrp_pkg::ST_RACK ##1 q.state == itrp_pkg::ST_IGNORE);
    c_timeout: cover property (q.ok_s && tout);
endmodule

// *** test/itrp_ctrl_model.sv ***
// Behavioural two-wire bus controller facing the target port
`timescale 1ns/1ns
module itrp_ctrl_model (
    output logic      scl_out,
    output logic      sda_oe_out,
    input  wire logic sda_in
);
    localparam int Q = 400;
    // Idle bus, both lines released
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // Data falls while clock high, also used as repeated start
    task start();
        #Q sda_oe_out = 1'b0;
        #Q scl_out = 1'b1;
        #Q sda_oe_out = 1'b1;
        #Q scl_out = 1'b0;
    endtask
    // Data rises while clock high, ends the transaction
    task stop();
        #Q sda_oe_out = 1'b1;
        #Q scl_out = 1'b1;
        #Q sda_oe_out = 1'b0;
        #Q;
    endtask
    // Eight bits MSB first, then the ninth acknowledge bit
    task xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] r, output logic acked);
        logic [8:0] w;
        logic [8:0] s;
        w = {d, ack_bit};
        for (int i = 8; i >= 0; i--) begin
            #Q sda_oe_out = ~w[i];
            #Q scl_out = 1'b1;
            #Q s[i] = sda_in;
            #Q scl_out = 1'b0;
        end
        r = s[8:1];
        acked = ~s[0];
    endtask
endmodule

// *** test/i2c_target_register_port_tb.sv ***
// Self-checking bench for the two-wire target register port
`timescale 1ns/1ns
module i2c_target_register_port_tb;
    logic        sys_clk_in;
    logic        link_clk_in;
    logic        rst;
    logic        backup;
    logic        lvf;
    wire logic   scl;
    wire logic   m_oe;
    wire logic   d_oe;
    wire logic   ok;
    wire logic   ws;
    wire logic [7:0] wa;
    wire logic [7:0] wd;
    wire logic   sda_line = ~(m_oe | d_oe);
    int          error_cnt = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;
    logic [15:0] wq[$];
    logic [7:0]  r;
    logic        a;

    itrp_target #(.DEB_SHORT_CYCLES(20), .DEB_LONG_CYCLES(60), .TOUT_CYCLES(8000)) dut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(rst), .link_clk_in(link_clk_in), .link_rst_in(rst),
        .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_out(d_oe),
        .backup_supply_state_in(backup), .low_voltage_flag_in(lvf), .access_ok_out(ok),
        .wr_strobe_out(ws), .wr_addr_out(wa), .wr_data_out(wd));
    itrp_ctrl_model m (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda_line));

    // Clocks, link clock offset in phase
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #16 link_clk_in = ~link_clk_in;
    end
    // Write log and hang guard
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (ws === 1'b1) wq.push_back({wa, wd});
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude();
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wait_ok(output int k);
        k = 0;
        while (ok !== 1'b1 && k < 200) begin
            @(posedge sys_clk_in);
            k++;
        end
        #200;
    endtask
    // Pointer load then three stores wrapping past FF
    task t_write();
        m.start();
        m.xfer(8'ha2, 1'b1, r, a);
        chk(a, 1'b1);
        m.xfer(8'hfe, 1'b1, r, a);
        chk(a, 1'b1);
        for (int i = 1; i <= 3; i++) begin
            m.xfer(8'(8'h11 * i), 1'b1, r, a);
            chk(a, 1'b1);
        end
        m.stop();
        repeat (20) @(posedge sys_clk_in);
        chk(16'(wq.size()), 16'h0003);
        for (int i = 0; i < 3; i++) chk(wq[i], {8'(8'hfe + i), 8'(8'h11 * (i + 1))});
        $display("write burst done");
    endtask
    // Chosen register read across a repeated start
    task t_rd_at();
        m.start();
        m.xfer(8'ha2, 1'b1, r, a);
        m.xfer(8'hfe, 1'b1, r, a);
        m.start();
        m.xfer(8'ha3, 1'b1, r, a);
        chk(a, 1'b1);
        m.xfer(8'hff, 1'b0, r, a);
        chk(r, 8'h11);
        m.xfer(8'hff, 1'b1, r, a);
        chk(r, 8'h22);
        chk(d_oe, 1'b0);
        m.stop();
        $display("chosen read done");
    endtask
    // Plain read goes on from the pointer
    task t_rd_plain();
        m.start();
        m.xfer(8'ha3, 1'b1, r, a);
        m.xfer(8'hff, 1'b1, r, a);
        chk(r, 8'h33);
        m.stop();
        $display("plain read done");
    endtask
    // Foreign address is neither acknowledged nor stored
    task t_bad();
        m.start();
        m.xfer(8'ha4, 1'b1, r, a);
        chk(a, 1'b0);
        m.xfer(8'h00, 1'b1, r, a);
        chk(a, 1'b0);
        m.stop();
        $display("foreign address done");
    endtask
    // Stalled transaction is dropped
    task t_timeout();
        m.start();
        m.xfer(8'ha2, 1'b1, r, a);
        #(8100 * 32);
        m.xfer(8'h5a, 1'b1, r, a);
        chk(a, 1'b0);
        m.stop();
        chk(16'(wq.size()), 16'h0003);
        $display("timeout done");
    endtask
    // Backup supply and both debounce lengths
    task t_backup();
        @(posedge sys_clk_in) backup <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        chk(ok, 1'b0);
        m.start();
        m.xfer(8'ha2, 1'b1, r, a);
        chk(a, 1'b0);
        @(posedge sys_clk_in) backup <= 1'b0;
        wait_ok(n);
        chk(n <= 30, 1'b1);
        m.stop();
        @(posedge sys_clk_in) backup <= 1'b1;
        lvf <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        backup <= 1'b0;
        lvf <= 1'b0;
        wait_ok(n);
        chk(n > 30 && n <= 70, 1'b1);
        m.start();
        m.xfer(8'ha2, 1'b1, r, a);
        chk(a, 1'b1);
        m.xfer(8'hfe, 1'b1, r, a);
        chk(a, 1'b1);
        m.start();
        m.xfer(8'ha3, 1'b1, r, a);
        m.xfer(8'hff, 1'b1, r, a);
        chk(r, 8'h11);
        m.stop();
        $display("backup done");
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        backup = 1'b0;
        lvf = 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rst <= 1'b0;
        wait_ok(n);
        t_write();
        t_rd_at();
        t_rd_plain();
        t_bad();
        t_timeout();
        t_backup();
        conclude();
    end
endmodule
